/* pkg/twe_pkg.sv */
// Constants, states and carrier types of the two-wire EEPROM slave.
package twe_pkg;

    // Array and page geometry.
    localparam int MEM_DEPTH  = 256;
    localparam int PAGE_BYTES = 16;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;

    // Slave address layout: fixed type code above the select bits.
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic       RW_READ  = 1'b1;

    // Bit counter values: eight data bits, then the acknowledge slot.
    localparam logic [3:0] CNT_ACK  = 4'h8;
    localparam logic [3:0] CNT_DONE = 4'h9;

    // Programming time, longest figure, rounded down to clock cycles.
    localparam int CLK_PERIOD_NS = 8;
    localparam int PROG_TIME_MS  = 5;
    localparam int PROG_CYCLES   = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIMER_W       = 20;

    // Protocol states; the spare code 3'b111 is illegal.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WORD  = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_PROG  = 3'b101,
        ST_WAIT  = 3'b110
    } twe_state_e;

    // Asynchronous pins that are synchronised together.
    typedef struct packed {
        logic       supply_ok;
        logic       write_protect;
        logic [2:0] chip_sel;
        logic       sda;
        logic       scl;
    } twe_pins_s;

    // Level of the pins while the synchroniser is in reset.
    localparam twe_pins_s PINS_IDLE = '{
        supply_ok: 1'b0, write_protect: 1'b0, chip_sel: 3'h0,
        sda: 1'b1, scl: 1'b1};

    // Whole state of the slave controller.
    typedef struct packed {
        twe_state_e           state;
        logic [3:0]           cnt;
        logic [7:0]           shreg;
        logic [7:0]           txb;
        logic [7:0]           ptr;
        logic [15:0][7:0]     pbuf;
        logic [15:0]          mask;
        logic [TIMER_W-1:0]   timer;
        logic                 sda_oe;
        logic                 busy;
        logic                 standby;
        logic                 scl_d;
        logic                 sda_d;
    } twe_state_s;

    localparam twe_state_s RESET_STATE = '{
        state: ST_IDLE, standby: 1'b1, scl_d: 1'b1, sda_d: 1'b1,
        default: '0};

endpackage

/* logic/twe_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels.
module twe_sync #(
    parameter int             W       = 7,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } twe_sync_s;

    twe_sync_s st;
    twe_sync_s next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.meta = d;
        next_st.sync = st.meta;
    end

    // Both stages take the idle level under reset.
    always_ff @(posedge clock) begin
        if (srst) begin
            st <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.sync;

endmodule

/* logic/twe_eeprom_slave.sv */
// Two-wire EEPROM slave controller with array, page buffer and timer.
// Overview of operation
// - Hold 256 bytes of 8 bits, arranged as pages of 16 bytes.
// - A short page write programs only the bytes actually received.
// - Programming is self-timed and ends within 5 ms.
// - Below the supply threshold, ignore the bus and never write.
// - When supply becomes good, reset the controller into standby.
// - When supply drops below threshold, fall back to standby.
// - A stop condition returns to standby unless programming runs.
// - Data line is open drain: only pulled low, otherwise released.
// - Serial clock is input only; all transfers follow its edges.
// - Three select pins must match address bits; eight per bus.
// - Unconnected select pins read as logic zero; the logic has no pull-downs and relies on the board for this.
// - Write protect high keeps the whole array unchanged; it is sampled only at the stop, not during programming.
// - Write protect low or floating allows normal writes; floating reads low only through board pull-downs, not in the logic.
// - Address byte holds 1010, three select bits, direction bit.
// - Direction bit one means read, zero means write.
// - Page writes step only the low four address bits, wrapping.
// - No acknowledge to the address while programming runs.
module twe_eeprom_slave #(
    parameter int PROG_CYCLES = twe_pkg::PROG_CYCLES
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic scl_clk,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic chip_select_bit_0,
    input  wire logic chip_select_bit_1,
    input  wire logic chip_select_bit_2,
    input  wire logic write_protect,
    input  wire logic supply_ok,
    output logic      busy,
    output logic      standby
);

    localparam logic [twe_pkg::TIMER_W-1:0] PROG_LAST =
        twe_pkg::TIMER_W'(PROG_CYCLES - 1);

    twe_pkg::twe_state_s st;
    twe_pkg::twe_state_s next_st;
    twe_pkg::twe_pins_s  pin_raw;
    twe_pkg::twe_pins_s  pin_s;

    logic [twe_pkg::DATA_W-1:0] mem [twe_pkg::MEM_DEPTH];
    logic                       link_bit;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_ev;
    logic                       stop_ev;
    logic                       match;
    logic                       commit;
    logic [7:0]                 rd_byte;

    // Pins are grouped for the synchroniser; board pull-downs make
    // floating select and protect pins read low.
    assign pin_raw = '{
        supply_ok:     supply_ok,
        write_protect: write_protect,
        chip_sel:      {chip_select_bit_2, chip_select_bit_1,
                        chip_select_bit_0},
        sda:           sda_in,
        scl:           scl_clk};

    twe_sync #(
        .W       ($bits(twe_pkg::twe_pins_s)),
        .RST_VAL (twe_pkg::PINS_IDLE)
    ) u_sync (
        .clock (clock),
        .srst  (srst),
        .d     (pin_raw),
        .q     (pin_s)
    );

    // The data bit is caught on the master's own clock edge and read in
    // the system domain only after the synchronised clock has risen.
    always_ff @(posedge scl_clk) begin
        link_bit <= sda_in;
    end

    // Bus events seen through the synchronised levels.
    assign scl_rise = pin_s.scl & ~st.scl_d;
    assign scl_fall = ~pin_s.scl & st.scl_d;
    assign start_ev = pin_s.scl & st.scl_d & st.sda_d & ~pin_s.sda;
    assign stop_ev  = pin_s.scl & st.scl_d & ~st.sda_d & pin_s.sda;

    // Address byte decode against type code and select pins.
    assign match = (st.shreg[7:4] == twe_pkg::DEV_TYPE) &&
                   (st.shreg[3:1] == pin_s.chip_sel);

    // Programming ends on the last timer count.
    assign commit = (st.state == twe_pkg::ST_PROG) &&
                    (st.timer == PROG_LAST) && pin_s.supply_ok;

    assign rd_byte = mem[st.ptr];

    // Next-state logic of the whole controller.
    always_comb begin
        next_st       = st;
        next_st.scl_d = pin_s.scl;
        next_st.sda_d = pin_s.sda;
        if (!pin_s.supply_ok) begin
            // Low supply holds the controller in standby, idle on the bus.
            next_st       = twe_pkg::RESET_STATE;
            next_st.scl_d = pin_s.scl;
            next_st.sda_d = pin_s.sda;
        end else if (st.state == twe_pkg::ST_PROG) begin
            // The bus is ignored while programming runs.
            next_st.sda_oe = 1'b0;
            if (st.timer == PROG_LAST) begin
                next_st.state = twe_pkg::ST_IDLE;
                next_st.timer = '0;
                next_st.mask  = '0;
            end else begin
                next_st.timer = st.timer + 1'b1;
            end
        end else if (start_ev) begin
            next_st.state  = twe_pkg::ST_ADDR;
            next_st.cnt    = '0;
            next_st.sda_oe = 1'b0;
        end else if (stop_ev) begin
            next_st.sda_oe = 1'b0;
            next_st.cnt    = '0;
            if ((|st.mask) && !pin_s.write_protect) begin
                next_st.state = twe_pkg::ST_PROG;
                next_st.timer = '0;
            end else begin
                next_st.state = twe_pkg::ST_IDLE;
                next_st.mask  = '0;
            end
        end else if (st.state inside {twe_pkg::ST_ADDR, twe_pkg::ST_WORD,
                                      twe_pkg::ST_WDATA,
                                      twe_pkg::ST_RDATA}) begin
            if (scl_rise) begin
                if (st.cnt < twe_pkg::CNT_ACK) begin
                    next_st.shreg = {st.shreg[6:0], link_bit};
                    next_st.cnt   = st.cnt + 4'h1;
                end else if (st.state == twe_pkg::ST_RDATA && link_bit) begin
                    // Master did not acknowledge: stop sending.
                    next_st.state = twe_pkg::ST_WAIT;
                end
            end
            if (scl_fall) begin
                if (st.cnt == twe_pkg::CNT_ACK) begin
                    next_st.cnt = twe_pkg::CNT_DONE;
                    unique case (st.state)
                        twe_pkg::ST_ADDR: begin
                            if (match) begin
                                next_st.sda_oe = 1'b1;
                            end else begin
                                next_st.state = twe_pkg::ST_WAIT;
                            end
                        end
                        twe_pkg::ST_WORD: begin
                            next_st.sda_oe = 1'b1;
                            next_st.ptr    = st.shreg;
                            next_st.mask   = '0;
                        end
                        twe_pkg::ST_WDATA: begin
                            // Protected writes are still acknowledged.
                            next_st.sda_oe              = 1'b1;
                            next_st.pbuf[st.ptr[3:0]]   = st.shreg;
                            next_st.mask[st.ptr[3:0]]   = 1'b1;
                            next_st.ptr[3:0] = st.ptr[3:0] + 4'h1;
                        end
                        twe_pkg::ST_RDATA: begin
                            next_st.sda_oe = 1'b0;
                            next_st.ptr    = st.ptr + 8'h01;
                        end
                        default: begin
                            next_st.state = twe_pkg::ST_WAIT;
                        end
                    endcase
                end else if (st.cnt == twe_pkg::CNT_DONE) begin
                    next_st.cnt    = '0;
                    next_st.sda_oe = 1'b0;
                    if (st.state == twe_pkg::ST_ADDR) begin
                        next_st.state = (st.shreg[0] == twe_pkg::RW_READ) ?
                            twe_pkg::ST_RDATA : twe_pkg::ST_WORD;
                    end else if (st.state == twe_pkg::ST_WORD) begin
                        next_st.state = twe_pkg::ST_WDATA;
                    end
                    if (next_st.state == twe_pkg::ST_RDATA) begin
                        // Load the byte and drive its first bit at once.
                        next_st.txb    = rd_byte;
                        next_st.sda_oe = ~rd_byte[7];
                    end
                end else if (st.state == twe_pkg::ST_RDATA &&
                             st.cnt != 4'h0) begin
                    next_st.sda_oe = ~st.txb[~st.cnt[2:0]];
                end
            end
        end
        next_st.busy    = (next_st.state == twe_pkg::ST_PROG);
        next_st.standby = (next_st.state == twe_pkg::ST_IDLE);
    end

    // State register of the controller.
    always_ff @(posedge clock) begin
        if (srst) begin
            st <= twe_pkg::RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // Programming writes only the received bytes of the buffered page.
    always_ff @(posedge clock) begin
        if (commit && !srst) begin
            for (int i = 0; i < twe_pkg::PAGE_BYTES; i++) begin
                if (st.mask[i]) begin
                    mem[{st.ptr[7:4], 4'(i)}] <= st.pbuf[i];
                end
            end
        end
    end

    // The pin only ever pulls low; the enable decides whether it does.
    assign sda_out = 1'b0;
    assign sda_oe  = st.sda_oe;
    assign busy    = st.busy;
    assign standby = st.standby;

    // Checks on the controller, all in the system clock domain.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_no_ack_busy;
        st.busy |-> !st.sda_oe;
    endproperty
    a_no_ack_busy: assert property (p_no_ack_busy)
        else $error("Data line driven while programming.");

    property p_supply_low;
        !pin_s.supply_ok |=> st.standby && !st.sda_oe && !st.busy;
    endproperty
    a_supply_low: assert property (p_supply_low)
        else $error("Activity while supply is low.");

    property p_supply_rise;
        $rose(pin_s.supply_ok) |-> st.state == twe_pkg::ST_IDLE;
    endproperty
    a_supply_rise: assert property (p_supply_rise)
        else $error("Not in standby when supply became good.");

    property p_prog_ends;
        st.busy && st.timer == PROG_LAST && pin_s.supply_ok |=>
            !st.busy && st.standby;
    endproperty
    a_prog_ends: assert property (p_prog_ends)
        else $error("Programming did not end on the last count.");

    property p_prog_bound;
        st.busy |-> st.timer <= PROG_LAST;
    endproperty
    a_prog_bound: assert property (p_prog_bound)
        else $error("Programming timer ran past its limit.");

    property p_wp_blocks;
        $rose(st.busy) |-> !$past(pin_s.write_protect) && $past(stop_ev);
    endproperty
    a_wp_blocks: assert property (p_wp_blocks)
        else $error("Programming started without a stop or under protect.");

    property p_stop_standby;
        stop_ev && !st.busy && pin_s.supply_ok |=>
            st.state inside {twe_pkg::ST_IDLE, twe_pkg::ST_PROG};
    endproperty
    a_stop_standby: assert property (p_stop_standby)
        else $error("Stop did not end the transfer.");

    property p_addr_mismatch;
        st.state == twe_pkg::ST_ADDR && scl_fall &&
            st.cnt == twe_pkg::CNT_ACK && !match
            |=> !st.sda_oe [*2];
    endproperty
    a_addr_mismatch: assert property (p_addr_mismatch)
        else $error("Acknowledged a foreign slave address.");

    property p_drive_scl_low;
        $changed(st.sda_oe) && $past(pin_s.supply_ok) &&
            !$past(start_ev) && !$past(stop_ev) |-> !$past(pin_s.scl);
    endproperty
    a_drive_scl_low: assert property (p_drive_scl_low)
        else $error("Data line changed while clock was high.");

    property p_page_hold;
        st.state == twe_pkg::ST_WDATA &&
            $past(st.state) == twe_pkg::ST_WDATA |->
            st.ptr[7:4] == $past(st.ptr[7:4]);
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("Page bits changed during a page write.");

    property p_addr_ack;
        st.state == twe_pkg::ST_ADDR && scl_fall &&
            st.cnt == twe_pkg::CNT_ACK && match && pin_s.supply_ok
            |=> st.sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("Own slave address was not acknowledged.");

    property p_data_ack;
        st.state == twe_pkg::ST_WDATA && scl_fall &&
            st.cnt == twe_pkg::CNT_ACK && pin_s.supply_ok
            |=> st.sda_oe;
    endproperty
    a_data_ack: assert property (p_data_ack)
        else $error("Data byte was not acknowledged.");

    property p_ptr_step;
        st.state == twe_pkg::ST_WDATA && scl_fall &&
            st.cnt == twe_pkg::CNT_ACK && pin_s.supply_ok
            |=> st.ptr[3:0] == $past(st.ptr[3:0]) + 4'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("Page pointer did not step by one.");

    property p_busy_hold;
        st.busy && st.timer != PROG_LAST && pin_s.supply_ok |=> st.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("Programming left before its last count.");

    property p_wp_drop;
        stop_ev && pin_s.write_protect && !st.busy && pin_s.supply_ok
            |=> !st.busy && st.mask == '0;
    endproperty
    a_wp_drop: assert property (p_wp_drop)
        else $error("Protected write kept its buffered bytes.");

    // Main scenarios worth seeing.
    c_prog_start: cover property ($rose(st.busy));
    c_read_byte: cover property (st.state == twe_pkg::ST_RDATA &&
                                 st.cnt == twe_pkg::CNT_DONE);
    c_poll_busy: cover property (st.busy && start_ev);
    c_page_wrap: cover property (st.state == twe_pkg::ST_WDATA &&
                                 st.ptr[3:0] == 4'hf && scl_fall);
    c_protected: cover property (stop_ev && (|st.mask) &&
                                 pin_s.write_protect);

endmodule

/* verif/twe_bus_master.sv */
// Behavioural two-wire bus master that drives the serial clock and data.
module twe_bus_master (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;

    // The clock idles high and the data line is released between frames.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_low = 1'b0;
        #(HALF / 2);
        scl = 1'b1;
        #HALF;
        sda_low = 1'b1;
        #HALF;
        scl = 1'b0;
    endtask

    // Stop: data rises while the clock is high, then the clock stands still.
    task automatic stop();
        #(HALF / 4);
        sda_low = 1'b1;
        #(HALF / 4);
        scl = 1'b1;
        #HALF;
        sda_low = 1'b0;
        #HALF;
    endtask

    // One clock pulse; data is set well after the fall and held through high.
    task automatic bit_cycle(input logic v, output logic s);
        #(HALF / 4);
        sda_low = ~v;
        #(HALF * 3 / 4);
        scl = 1'b1;
        #(HALF / 2);
        s = sda_wire;
        #(HALF / 2);
        scl = 1'b0;
    endtask

    // Byte out, most significant bit first, then the acknowledge slot.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    // Byte in, then our acknowledge, or a release that ends the read.
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(~ack, s);
    endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench of the two-wire EEPROM slave against a byte model.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 400;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic       wp = 1'b0;
    logic       supply_ok = 1'b0;
    logic [2:0] cs = 3'h0;
    logic       scl;
    logic       sda_low;
    logic       sda_wire;
    logic       sda_out;
    logic       sda_oe;
    logic       busy;
    logic       standby;
    logic [7:0] ptr_m;
    int         mem [256];
    int         fails = 0;
    int         compares = 0;
    int         bcnt = 0;
    int unsigned seed_val;

    always #4 clk = ~clk;
    // Pull-up on the data wire; either party may pull it low.
    assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    twe_eeprom_slave #(.PROG_CYCLES(PROG)) DUT (
        .clock(clk), .srst(srst), .scl_clk(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_bit_0(cs[0]), .chip_select_bit_1(cs[1]),
        .chip_select_bit_2(cs[2]), .write_protect(wp),
        .supply_ok(supply_ok), .busy(busy), .standby(standby));

    twe_bus_master mst (.scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));

    // Counts the cycles that the programming flag stands high.
    always @(posedge clk) begin
        if (busy === 1'b1) begin
            bcnt <= bcnt + 1;
        end
    end

    task automatic chk_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp,
                            input logic got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // The slave only ever pulls the data pin low.
    always @(posedge scl) begin
        if (sda_oe === 1'b1) begin
            chk_flag("pin level", 1'b0, sda_out);
        end
    end

    function automatic logic [7:0] sel(input logic rw);
        return {twe_pkg::DEV_TYPE, cs, rw};
    endfunction

    task automatic head(input logic [7:0] b, input logic exp);
        logic a;
        mst.start();
        mst.send_byte(b, a);
        chk_flag("address ack", exp, a);
    endtask

    // Byte address then n data bytes; the model commits unless protected.
    task automatic wr(input logic [7:0] p, input int n);
        logic       a;
        logic [7:0] d;
        int         pend [int];
        head(sel(1'b0), 1'b1);
        mst.send_byte(p, a);
        chk_flag("pointer ack", 1'b1, a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            mst.send_byte(d, a);
            chk_flag("data ack", 1'b1, a);
            pend[{p[7:4], 4'(p[3:0] + 4'(i))}] = d;
        end
        @(negedge clk);
        bcnt = 0;
        mst.stop();
        if (wp === 1'b0) begin
            foreach (pend[k]) mem[k] = pend[k];
        end
        ptr_m = {p[7:4], 4'(p[3:0] + 4'(n))};
        repeat (8) @(negedge clk);
        chk_flag("busy", ~wp, busy);
        if (wp === 1'b0) begin
            head(sel(1'b0), 1'b0);
            mst.stop();
            for (int t = 0; t < PROG + 50 && busy !== 1'b0; t++) begin
                @(negedge clk);
            end
            chk_flag("busy done", 1'b0, busy);
            chk_flag("time", 1'b1, bcnt >= PROG - 1 && bcnt <= PROG + 1);
        end
        chk_flag("standby", 1'b1, standby);
    endtask

    // Optional byte address, repeated start, then n bytes read back.
    task automatic rd(input logic [7:0] p, input int n, input logic rnd);
        logic       a;
        logic [7:0] d;
        if (rnd) begin
            head(sel(1'b0), 1'b1);
            mst.send_byte(p, a);
            chk_flag("pointer ack", 1'b1, a);
            ptr_m = p;
        end
        head(sel(1'b1), 1'b1);
        for (int i = 0; i < n; i++) begin
            mst.recv_byte(i < n - 1, d);
            chk_val("read byte", mem[ptr_m], {24'h0, d});
            ptr_m = ptr_m + 8'h01;
        end
        mst.stop();
        repeat (8) @(negedge clk);
        chk_flag("standby", 1'b1, standby);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run time.
    initial begin
        #500000;
        fails++;
        give_verdict();
    end

    initial begin
        seed_val = $urandom(40535);
        repeat (20) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        chk_flag("standby", 1'b1, standby);
        chk_flag("busy", 1'b0, busy);
        head(sel(1'b0), 1'b0);
        mst.stop();
        @(negedge clk);
        supply_ok = 1'b1;
        cs = 3'($urandom);
        repeat (8) @(negedge clk);
        chk_flag("standby", 1'b1, standby);
        head({twe_pkg::DEV_TYPE, cs ^ 3'h5, 1'b0}, 1'b0);
        mst.stop();
        head({4'hb, cs, 1'b0}, 1'b0);
        mst.stop();
        wr(8'h50, 16);
        rd(8'h50, 16, 1'b1);
        wr(8'h5e, 3);
        rd(8'h50, 16, 1'b1);
        wr(8'h20, 18);
        rd(8'h00, 3, 1'b0);
        @(negedge clk);
        wp = 1'b1;
        wr(8'h50, 4);
        rd(8'h50, 4, 1'b1);
        @(negedge clk);
        wp = 1'b0;
        cs = 3'h0;
        wr(8'hf0, 16);
        wr(8'hff, 2);
        rd(8'hf0, 16, 1'b1);
        head(sel(1'b0), 1'b1);
        @(negedge clk);
        supply_ok = 1'b0;
        repeat (8) @(negedge clk);
        chk_flag("standby", 1'b1, standby);
        mst.stop();
        @(negedge clk);
        supply_ok = 1'b1;
        repeat (8) @(negedge clk);
        chk_flag("standby", 1'b1, standby);
        rd(8'h50, 2, 1'b1);
        give_verdict();
    end
endmodule
